// file: rtl/led_ptr_target.sv
// Two-wire bus target with control byte pointer and auto-increment for the LED registers
`default_nettype none

module led_ptr_target
    import led_ptr_pkg::*;
#(
    parameter logic [6:0] SOFT_RESET_ADDR = 7'h4B
)(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Bus pins, data is open drain
    input  wire logic                      sclIn,
    input  wire logic                      sdaIn,
    output logic                           sdaOut,
    output logic                           sdaOe,
    // Own target address from the address pins
    input  wire logic [6:0]                targetAddress,
    // Status towards the rest of the driver
    output logic                           softResetCall,
    output ctrl_byte_t                     controlByte,
    output logic      [REG_COUNT-1:0][7:0] regImage
);

    bus_event_t  ev;
    link_state_t state_reg, state_next;
    link_state_t afterAck_reg, afterAck_next;
    logic [3:0]  bitCount_reg, bitCount_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  txShift_reg, txShift_next;
    ctrl_byte_t  ctrl_reg, ctrl_next;
    logic        sdaOe_reg, sdaOe_next;
    logic        sdaOut_reg, sdaOut_next;
    logic        softReset_reg, softReset_next;
    logic        memWrEn;
    logic [7:0]  rdData;
    logic [7:0]  byteIn;
    logic [7:0]  primaryMode;
    logic        ownHit, broadcastHit, subHit, resetAddrSeen;
    logic        addrDone, stepNow;

    // ============================================================
    // Line sampling and register storage
    bus_line_front u_front (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .events  (ev)
    );

    led_reg_store u_store (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .wrEn     (memWrEn),
        .wrAddr   (ctrl_reg.pointer),
        .wrData   (byteIn),
        .rdAddr   (ctrl_reg.pointer),
        .rdData   (rdData),
        .regImage (regImage)
    );

    // ============================================================
    // Pointer stepping per increment mode
    function automatic logic [4:0] stepPointer(input ctrl_byte_t c);
        logic [4:0] first;
        logic [4:0] last;
        first = PTR_FIRST_ALL;
        last  = PTR_LAST_ALL;
        case (c.incrementMode)
            INC_ALL: begin
                first = PTR_FIRST_ALL;
                last  = PTR_LAST_ALL;
            end
            INC_BRIGHT: begin
                first = PTR_FIRST_BRIGHT;
                last  = PTR_LAST_BRIGHT;
            end
            INC_GROUP: begin
                first = PTR_FIRST_GROUP;
                last  = PTR_LAST_GROUP;
            end
            INC_BRIGHT_GROUP: begin
                first = PTR_FIRST_BRIGHT;
                last  = PTR_LAST_GROUP;
            end
            default: begin
                return c.pointer;
            end
        endcase
        // At or beyond the last map entry the pointer also falls back to the mode's first entry
        if (c.pointer == last || c.pointer >= PTR_LAST_ALL) begin
            return first;
        end
        return c.pointer + 5'h01;
    endfunction

    // ============================================================
    // Address decode against own, broadcast and enabled sub-group addresses
    always_comb begin
        byteIn        = {shift_reg[6:0], ev.sdaBit};
        primaryMode   = regImage[REG_PRIMARY_MODE];
        resetAddrSeen = (byteIn[7:1] == SOFT_RESET_ADDR);
        ownHit        = (byteIn[7:1] == targetAddress);
        broadcastHit  = primaryMode[BIT_BROADCAST_EN] &&
                        (byteIn[7:1] == regImage[REG_BROADCAST_ADDR][7:1]);
        subHit        = (primaryMode[BIT_SUBGRP1_EN] &&
                         byteIn[7:1] == regImage[REG_SUB_ADDR_1][7:1]) ||
                        (primaryMode[BIT_SUBGRP2_EN] &&
                         byteIn[7:1] == regImage[REG_SUB_ADDR_2][7:1]) ||
                        (primaryMode[BIT_SUBGRP3_EN] &&
                         byteIn[7:1] == regImage[REG_SUB_ADDR_3][7:1]);
    end

    // ============================================================
    // Transfer sequencing: address, control byte, data and acknowledges
    always_comb begin
        state_next     = state_reg;
        afterAck_next  = afterAck_reg;
        bitCount_next  = bitCount_reg;
        shift_next     = shift_reg;
        txShift_next   = txShift_reg;
        ctrl_next      = ctrl_reg;
        sdaOe_next     = sdaOe_reg;
        sdaOut_next    = 1'b0;
        softReset_next = 1'b0;
        memWrEn        = 1'b0;
        addrDone       = 1'b0;
        stepNow        = 1'b0;
        if (ev.startCond) begin
            // Repeated start also restarts the address phase
            state_next    = ST_ADDR;
            bitCount_next = 4'h0;
            sdaOe_next    = 1'b0;
        end else if (ev.stopCond) begin
            state_next = ST_IDLE;
            sdaOe_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_WAIT_STOP: begin
                    sdaOe_next = 1'b0;
                end
                ST_ADDR, ST_CTRL, ST_WDATA: begin
                    if (ev.sclRise) begin
                        shift_next    = byteIn;
                        bitCount_next = bitCount_reg + 4'h1;
                        if (bitCount_reg == BIT_LAST) begin
                            bitCount_next = 4'h0;
                            state_next    = ST_ACK_ARM;
                            afterAck_next = ST_WDATA;
                            if (state_reg == ST_ADDR) begin
                                addrDone = 1'b1;
                                if (resetAddrSeen) begin
                                    afterAck_next = ST_WAIT_STOP;
                                    if (byteIn[0]) begin
                                        state_next = ST_WAIT_STOP;
                                    end else begin
                                        softReset_next = 1'b1;
                                    end
                                end else if (ownHit || broadcastHit || subHit) begin
                                    // Reads keep the held pointer
                                    afterAck_next = byteIn[0] ? ST_RDATA : ST_CTRL;
                                end else begin
                                    state_next = ST_WAIT_STOP;
                                end
                            end else if (state_reg == ST_CTRL) begin
                                ctrl_next = byteIn;
                            end else begin
                                memWrEn   = 1'b1;
                                stepNow   = 1'b1;
                                // Only the pointer field moves
                                ctrl_next.pointer = stepPointer(ctrl_reg);
                            end
                        end
                    end
                end
                ST_ACK_ARM: begin
                    if (ev.sclFall) begin
                        sdaOe_next = 1'b1;
                        state_next = ST_ACK_OUT;
                    end
                end
                ST_ACK_OUT: begin
                    if (ev.sclFall) begin
                        state_next    = afterAck_reg;
                        bitCount_next = 4'h0;
                        sdaOe_next    = 1'b0;
                        if (afterAck_reg == ST_RDATA) begin
                            // First read byte comes from the held pointer
                            txShift_next  = rdData;
                            sdaOe_next    = ~rdData[7];
                            bitCount_next = 4'h1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (ev.sclFall) begin
                        if (bitCount_reg == BIT_ACK) begin
                            sdaOe_next = 1'b0;
                            state_next = ST_RACK;
                        end else begin
                            txShift_next  = {txShift_reg[6:0], 1'b0};
                            sdaOe_next    = ~txShift_reg[6];
                            bitCount_next = bitCount_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (ev.sclRise) begin
                        stepNow           = 1'b1;
                        ctrl_next.pointer = stepPointer(ctrl_reg);
                        afterAck_next     = ST_RDATA;
                        state_next        = (ev.sdaBit == ACK_LEVEL) ? ST_ACK_OUT : ST_WAIT_STOP;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    sdaOe_next = 1'b0;
                end
            endcase
        end
    end

    // Registers of the sequencer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg     <= ST_IDLE;
            afterAck_reg  <= ST_IDLE;
            bitCount_reg  <= 4'h0;
            shift_reg     <= 8'h00;
            txShift_reg   <= 8'h00;
            ctrl_reg      <= '0;
            sdaOe_reg     <= 1'b0;
            sdaOut_reg    <= 1'b0;
            softReset_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            afterAck_reg  <= afterAck_next;
            bitCount_reg  <= bitCount_next;
            shift_reg     <= shift_next;
            txShift_reg   <= txShift_next;
            ctrl_reg      <= ctrl_next;
            sdaOe_reg     <= sdaOe_next;
            sdaOut_reg    <= sdaOut_next;
            softReset_reg <= softReset_next;
        end
    end

    // Outputs straight from registers
    assign sdaOe         = sdaOe_reg;
    assign sdaOut        = sdaOut_reg;
    assign softResetCall = softReset_reg;
    assign controlByte   = ctrl_reg;

    // ============================================================
    // Checks
    ctrl_capture_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state_reg == ST_CTRL && ev.sclRise && bitCount_reg == BIT_LAST && !ev.startCond
         && !ev.stopCond) |=> (ctrl_reg == $past(byteIn)))
        else $error("control byte not captured");

    hold_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode == INC_NONE) |=> $stable(ctrl_reg.pointer))
        else $error("pointer moved in fixed mode");

    step_next_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode[2] && ctrl_reg.pointer == 5'h04) |=>
        (ctrl_reg.pointer == 5'h05))
        else $error("pointer did not advance");

    wrap_all_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode == INC_ALL && ctrl_reg.pointer == 5'h11) |=>
        (ctrl_reg.pointer == 5'h00))
        else $error("full map wrap wrong");

    wrap_bright_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode == INC_BRIGHT && ctrl_reg.pointer == 5'h09) |=>
        (ctrl_reg.pointer == 5'h02))
        else $error("brightness wrap wrong");

    wrap_group_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode == INC_GROUP && ctrl_reg.pointer == 5'h0B) |=>
        (ctrl_reg.pointer == 5'h0A))
        else $error("group wrap wrong");

    wrap_mixed_a: assert property (@(posedge clock) disable iff (sys_rst)
        (stepNow && ctrl_reg.incrementMode == INC_BRIGHT_GROUP && ctrl_reg.pointer == 5'h0B)
        |=> (ctrl_reg.pointer == 5'h02))
        else $error("combined wrap wrong");

    mode_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
        stepNow |=> $stable(ctrl_reg.incrementMode))
        else $error("increment mode changed by stepping");

    reset_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (addrDone && resetAddrSeen && byteIn[0]) |=>
        (state_reg == ST_WAIT_STOP) ##1 (!sdaOe)[*2])
        else $error("reset call acknowledged for read");

    broadcast_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        (addrDone && !primaryMode[BIT_BROADCAST_EN] && !ownHit && !subHit && !resetAddrSeen)
        |=> (state_reg == ST_WAIT_STOP))
        else $error("disabled address acknowledged");

    read_start_a: assert property (@(posedge clock) disable iff (sys_rst)
        (state_reg == ST_ACK_OUT && afterAck_reg == ST_RDATA && ev.sclFall && !ev.startCond
         && !ev.stopCond) |=> (txShift_reg == $past(rdData) && sdaOe == ~$past(rdData[7])))
        else $error("read did not start at pointer");

endmodule

`default_nettype wire

// file: rtl/led_ptr_pkg.sv
// Shared constants, register map and types for the LED driver register front end
`default_nettype none

package led_ptr_pkg;

    // ============================================================
    // Register map
    localparam int         REG_COUNT          = 18;
    localparam logic [4:0] REG_PRIMARY_MODE   = 5'h00;
    localparam logic [4:0] REG_SECONDARY_MODE = 5'h01;
    localparam logic [4:0] REG_LED0_BRIGHT    = 5'h02;
    localparam logic [4:0] REG_LED7_BRIGHT    = 5'h09;
    localparam logic [4:0] REG_GROUP_DUTY     = 5'h0A;
    localparam logic [4:0] REG_GROUP_FREQ     = 5'h0B;
    localparam logic [4:0] REG_OUT_STATE_LO   = 5'h0C;
    localparam logic [4:0] REG_OUT_STATE_HI   = 5'h0D;
    localparam logic [4:0] REG_SUB_ADDR_1     = 5'h0E;
    localparam logic [4:0] REG_SUB_ADDR_2     = 5'h0F;
    localparam logic [4:0] REG_SUB_ADDR_3     = 5'h10;
    localparam logic [4:0] REG_BROADCAST_ADDR = 5'h11;

    // ============================================================
    // Pointer rollover limits per increment mode
    localparam logic [4:0] PTR_FIRST_ALL    = 5'h00;
    localparam logic [4:0] PTR_LAST_ALL     = 5'h11;
    localparam logic [4:0] PTR_FIRST_BRIGHT = 5'h02;
    localparam logic [4:0] PTR_LAST_BRIGHT  = 5'h09;
    localparam logic [4:0] PTR_FIRST_GROUP  = 5'h0A;
    localparam logic [4:0] PTR_LAST_GROUP   = 5'h0B;

    // ============================================================
    // Primary mode control bit positions
    localparam int BIT_BROADCAST_EN = 0;
    localparam int BIT_SUBGRP3_EN   = 1;
    localparam int BIT_SUBGRP2_EN   = 2;
    localparam int BIT_SUBGRP1_EN   = 3;

    // ============================================================
    // Values after reset and writable bits per register
    localparam logic [7:0] REG_RESET [REG_COUNT] = '{
        8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h92, 8'h94, 8'h98, 8'h90};
    localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
        8'h1F, 8'h2F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    // ============================================================
    // Bus constants and types
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    localparam logic       ACK_LEVEL   = 1'b0;

    typedef enum logic [2:0] {
        INC_NONE         = 3'b000,
        INC_ALL          = 3'b100,
        INC_BRIGHT       = 3'b101,
        INC_GROUP        = 3'b110,
        INC_BRIGHT_GROUP = 3'b111
    } incr_mode_t;

    typedef struct packed {
        logic [2:0] incrementMode;
        logic [4:0] pointer;
    } ctrl_byte_t;

    typedef struct packed {
        logic sclRise;
        logic sclFall;
        logic startCond;
        logic stopCond;
        logic sdaBit;
    } bus_event_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ACK_ARM   = 4'h2,
        ST_ACK_OUT   = 4'h3,
        ST_CTRL      = 4'h4,
        ST_WDATA     = 4'h5,
        ST_RDATA     = 4'h6,
        ST_RACK      = 4'h7,
        ST_WAIT_STOP = 4'h8
    } link_state_t;

endpackage

`default_nettype wire

// file: rtl/bus_line_front.sv
// Bus line sampler that turns clock and data levels into edge and condition events
`default_nettype none

module bus_line_front
    import led_ptr_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Bus lines
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    // Decoded events
    output bus_event_t      events
);

    logic sclNow_reg, sclNow_next;
    logic sdaNow_reg, sdaNow_next;
    logic sclOld_reg, sclOld_next;
    logic sdaOld_reg, sdaOld_next;

    // ============================================================
    // Two sample stages per line
    always_comb begin
        sclNow_next = sclIn;
        sdaNow_next = sdaIn;
        sclOld_next = sclNow_reg;
        sdaOld_next = sdaNow_reg;
    end

    // Idle bus reads high after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclNow_reg <= 1'b1;
            sdaNow_reg <= 1'b1;
            sclOld_reg <= 1'b1;
            sdaOld_reg <= 1'b1;
        end else begin
            sclNow_reg <= sclNow_next;
            sdaNow_reg <= sdaNow_next;
            sclOld_reg <= sclOld_next;
            sdaOld_reg <= sdaOld_next;
        end
    end

    // Data moving while the clock is high marks start or stop
    always_comb begin
        events.sclRise   = sclNow_reg & ~sclOld_reg;
        events.sclFall   = ~sclNow_reg & sclOld_reg;
        events.startCond = sclNow_reg & sclOld_reg & ~sdaNow_reg & sdaOld_reg;
        events.stopCond  = sclNow_reg & sclOld_reg & sdaNow_reg & ~sdaOld_reg;
        events.sdaBit    = sdaNow_reg;
    end

endmodule

`default_nettype wire

// file: rtl/led_reg_store.sv
// Register array of the LED driver with masked writes and a registered read port
`default_nettype none

module led_reg_store
    import led_ptr_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Write port
    input  wire logic                      wrEn,
    input  wire logic [4:0]                wrAddr,
    input  wire logic [7:0]                wrData,
    // Read port
    input  wire logic [4:0]                rdAddr,
    output logic      [7:0]                rdData,
    // Whole register image
    output logic      [REG_COUNT-1:0][7:0] regImage
);

    logic [7:0] entry_reg  [REG_COUNT];
    logic [7:0] entry_next [REG_COUNT];
    logic [7:0] rdData_reg, rdData_next;

    // ============================================================
    // One storage entry per register; read-only bits keep their value
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
        always_comb begin
            entry_next[i] = entry_reg[i];
            if (wrEn && wrAddr == 5'(i)) begin
                entry_next[i] = (wrData & REG_WMASK[i]) | (entry_reg[i] & ~REG_WMASK[i]);
            end
        end

        // Reset loads the power-up contents
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                entry_reg[i] <= REG_RESET[i];
            end else begin
                entry_reg[i] <= entry_next[i];
            end
        end

        assign regImage[i] = entry_reg[i];
    end

    // ============================================================
    // Registered read; pointers past the map read as zero
    always_comb begin
        rdData_next = 8'h00;
        if (rdAddr < 5'(REG_COUNT)) begin
            rdData_next = entry_reg[rdAddr];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign rdData = rdData_reg;

    // ============================================================
    // Checks
    write_lands_a: assert property (@(posedge clock) disable iff (sys_rst)
        (wrEn && wrAddr < 5'(REG_COUNT)) |=>
        (((regImage[$past(wrAddr)] ^ $past(wrData)) & REG_WMASK[$past(wrAddr)]) == 8'h00))
        else $error("register write did not land");

    reset_values_a: assert property (@(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> (regImage[REG_BROADCAST_ADDR] == 8'h90 &&
        regImage[REG_PRIMARY_MODE][BIT_BROADCAST_EN] &&
        !regImage[REG_PRIMARY_MODE][BIT_SUBGRP1_EN] &&
        !regImage[REG_PRIMARY_MODE][BIT_SUBGRP2_EN] &&
        !regImage[REG_PRIMARY_MODE][BIT_SUBGRP3_EN]))
        else $error("power-up address defaults wrong");

endmodule

`default_nettype wire

// file: bench/bus_master_model.sv
// Two-wire bus controller model
`default_nettype none
module bus_master_model (
    // Clock and bus lines
    input  wire logic clock,
    input  wire logic sdaLine,
    output var  logic sclLine,
    output var  logic sdaDrive
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclLine = 1'b1;
        sdaDrive = 1'b1;
    end
    // Wait n edges, then step off the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One bit: setup, high phase with sample, low phase
    task automatic bitx(input logic b, output logic s);
        sdaDrive = b;
        hold(4);
        sclLine = 1'b1;
        hold(3);
        s = sdaLine;
        hold(3);
        sclLine = 1'b0;
        hold(1);
    endtask
    task automatic start();
        sdaDrive = 1'b1;
        sclLine = 1'b1;
        hold(4);
        sdaDrive = 1'b0;
        hold(4);
        sclLine = 1'b0;
        hold(2);
    endtask
    task automatic stop();
        sdaDrive = 1'b0;
        hold(4);
        sclLine = 1'b1;
        hold(4);
        sdaDrive = 1'b1;
        hold(4);
    endtask
    // Byte MSB first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(m, a);
    endtask
endmodule
`default_nettype wire

// file: bench/led_driver_register_pointer_tb_top.sv
// Self-checking bench for the LED register pointer front end
`default_nettype none
module led_driver_register_pointer_tb_top import led_ptr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, sysRst = 1'b1, resetSeen = 1'b0, softResetCall, sdaOe, sdaOut;
    logic sclLine, sdaDrive;
    ctrl_byte_t ctrl;
    logic [REG_COUNT-1:0][7:0] regImage;
    int mismatches = 0, checks = 0;
    // Open-drain data line with pull-up: low when either side pulls it
    wire logic sdaLine = sdaDrive & (~sdaOe | sdaOut);
    initial forever #4 clock = ~clock;
    always @(posedge clock) if (softResetCall === 1'b1) resetSeen <= 1'b1;
    led_ptr_target dut (.clock(clock), .sys_rst(sysRst), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .targetAddress(7'h20), .softResetCall(softResetCall),
        .controlByte(ctrl), .regImage(regImage));
    bus_master_model bm (.clock(clock), .sdaLine(sdaLine), .sclLine(sclLine), .sdaDrive(sdaDrive));
    task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // Start plus address byte, ninth bit judged
    task automatic open(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        bm.start();
        bm.xfer(a, 1'b1, q, k);
        check("address ack", {7'h00, k}, e);
    endtask
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        logic k;
        bm.xfer(d, 1'b1, q, k);
        check("write ack", {7'h00, k}, 8'h00);
    endtask
    task automatic get(input logic m, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        bm.xfer(8'hFF, m, q, k);
        check("read data", q, e);
    endtask
    task automatic test_wrap();
        check("group address", regImage[REG_BROADCAST_ADDR], 8'h90);
        check("enables", {4'h0, regImage[0][3:0]}, 8'h01);
        open(8'h40, 8'h00);
        put(8'h90);
        put(8'hA5);
        put(8'hA0);
        put(8'h19);
        bm.stop();
        check("reg 10", regImage[16], 8'hA5);
        check("reg 11", regImage[17], 8'hA0);
        check("reg 00", regImage[0], 8'h19);
        check("control", ctrl, 8'h81);
        $display("wrap done");
    endtask
    // Per mode: control byte, final control, register hit second
    task automatic test_modes();
        logic [7:0] t [5][3] = '{'{8'hA9, 8'hA3, 8'h02}, '{8'hCB, 8'hCB, 8'h0A},
            '{8'hEB, 8'hE3, 8'h02}, '{8'hE4, 8'hE6, 8'h05}, '{8'h05, 8'h05, 8'h05}};
        for (int i = 0; i < 5; i++) begin
            open(8'h40, 8'h00);
            put(t[i][0]);
            put(8'h30 + i[7:0]);
            put(8'h60 + i[7:0]);
            bm.stop();
            check("mode control", ctrl, t[i][1]);
            check("mode data", regImage[t[i][2][4:0]], 8'h60 + i[7:0]);
        end
        open(8'h41, 8'h00);
        get(1'b0, 8'h64);
        get(1'b1, 8'h64);
        bm.stop();
        $display("modes done");
    endtask
    // Address, expected ninth bit, expected reset pulse seen
    task automatic test_addresses();
        logic [7:0] t [5][3] = '{'{8'hA0, 0, 0}, '{8'h92, 0, 0}, '{8'h94, 1, 0},
            '{8'h97, 1, 0}, '{8'h96, 0, 1}};
        for (int i = 0; i < 5; i++) begin
            open(t[i][0], t[i][1]);
            bm.stop();
            check("reset call", {7'h00, resetSeen}, t[i][2]);
        end
        // Switch broadcast response off, then its address must go unanswered
        open(8'h40, 8'h00);
        put(8'h00);
        put(8'h18);
        bm.stop();
        open(8'hA0, 8'h01);
        bm.stop();
        $display("addresses done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clock);
        #1 sysRst = 1'b0;
        repeat (4) @(posedge clock);
        test_wrap();
        test_modes();
        test_addresses();
        print_verdict();
    end
endmodule
`default_nettype wire
